// ==== shared/fsseq_pkg.sv ====
package fsseq_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_LIMITS  = 12'h004;
  localparam logic [11:0] OFS_FAIL    = 12'h008;
  localparam logic [11:0] OFS_COUNT   = 12'h00C;
  // ctrl fields
  localparam int CTRL_OV_EN     = 0;
  localparam int CTRL_OV_SDWN   = 1;
  localparam int CTRL_OV_DBNC   = 2;
  localparam int CTRL_FS_BYPASS = 4;
  // limits fields
  localparam int LIM_FS      = 0;
  localparam int LIM_WD      = 4;
  localparam int LIM_PERIOD  = 8;
  // fail flag positions
  localparam int FAIL_PU  = 0;
  localparam int FAIL_WD  = 1;
  localparam int FAIL_REG = 2;
  localparam int FAIL_TSD = 3;
  // count register fields
  localparam int CNT_FS    = 0;
  localparam int CNT_WD    = 4;
  localparam int CNT_STATE = 8;
  localparam int CNT_FS_CLR = 16;
  // counter reset and saturation values
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_MAX   = 4'hF;
  // timing
  localparam longint CLK_HZ       = 125_000_000;
  localparam longint CLK_MHZ      = 125;
  localparam longint MINUTE_S     = 60;
  localparam longint DBNC_10US_NS  = 10_000;
  localparam longint DBNC_100US_NS = 100_000;
  localparam longint DBNC_1MS_NS   = 1_000_000;
  localparam logic [39:0] MINUTE_CYCLES = 40'(MINUTE_S * CLK_HZ);
  localparam logic [16:0] DBNC_10US_CYC  = 17'((DBNC_10US_NS * CLK_MHZ + 999) / 1000);
  localparam logic [16:0] DBNC_100US_CYC = 17'((DBNC_100US_NS * CLK_MHZ + 999) / 1000);
  localparam logic [16:0] DBNC_1MS_CYC   = 17'((DBNC_1MS_NS * CLK_MHZ + 999) / 1000);
  // decrement period in minutes, indexed by select code
  localparam logic [5:0] FS_PERIOD_MIN [8] = '{6'h01, 6'h05, 6'h0A, 6'h0F,
                                               6'h14, 6'h1E, 6'h2D, 6'h3C};
  // debounce select codes
  localparam logic [1:0] DBNC_SEL_10US  = 2'h0;
  localparam logic [1:0] DBNC_SEL_100US = 2'h1;
endpackage

// ==== hw/fault_failsafe_sequencer.sv ====
`timescale 1ns/10ps
module fault_failsafe_sequencer #(
  parameter logic [39:0] MINUTE_CYCLES    = fsseq_pkg::MINUTE_CYCLES,
  parameter logic [16:0] DBNC_100US_CYCLES = fsseq_pkg::DBNC_100US_CYC,
  parameter logic [16:0] DBNC_1MS_CYCLES   = fsseq_pkg::DBNC_1MS_CYC
) (
  // clock, reset, enable
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_CLK_EN,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // analog comparators and pins, asynchronous
  input  wire logic        I_VIN_ABOVE_UV,
  input  wire logic        I_INPUT_OVERVOLTAGE_EVENT,
  input  wire logic        I_WATCHDOG_INPUT_PIN,
  // events from on-chip logic
  input  wire logic        I_WD_TIMER_EVENT,
  input  wire logic        I_TURN_ON,
  input  wire logic        I_TURN_OFF,
  input  wire logic        I_POWERUP_DONE,
  input  wire logic        I_POWERUP_FAIL,
  input  wire logic        I_POWERDOWN_DONE,
  input  wire logic        I_REG_FAIL,
  input  wire logic        I_THERMAL_FAIL,
  // fuse defaults
  input  wire logic [3:0]  I_FAILSAFE_LIMIT_DEFAULT,
  input  wire logic        I_FAILSAFE_BYPASS_DEFAULT,
  input  wire logic [2:0]  I_FAILSAFE_DECREMENT_PERIOD_SEL,
  input  wire logic [3:0]  I_WATCHDOG_EVENT_LIMIT_DEFAULT,
  input  wire logic        I_OVERVOLTAGE_ENABLE_DEFAULT,
  input  wire logic        I_OVERVOLTAGE_SHUTDOWN_DEFAULT,
  input  wire logic [1:0]  I_OVERVOLTAGE_DEBOUNCE_DEFAULT,
  // sequencer control and status
  output logic             O_FUSE_LOAD,
  output logic             O_POWERUP_REQ,
  output logic             O_POWERDOWN_REQ,
  output logic             O_REGULATORS_ON,
  output logic             O_WD_HARD_RESET,
  output logic             O_OV_IRQ,
  output logic             O_LOCKDOWN,
  output logic      [2:0]  O_STATE
);

  typedef enum logic [2:0] {
    ST_UNPOWERED, ST_LOW_POWER_OFF_STATE, ST_POWER_UP, ST_SYS_ON,
    ST_POWER_DOWN, ST_FS_TRANS, ST_LOCKDOWN
  } state_e;

  state_e      state;
  state_e      next_state;
  logic        uv_s1, uv_s2, uv_q;
  logic        ov_s1, ov_s2;
  logic        wdi_s1, wdi_s2, wdi_q;
  logic        uv_rise;
  logic [16:0] dbnc_cnt;
  logic [16:0] dbnc_target;
  logic        ov_deb, ov_deb_q, ov_evt;
  logic        wd_evt, wd_max;
  logic [3:0]  next_wd_cnt;
  logic        fault_evt;
  logic [3:0]  fault_src;
  logic [3:0]  cause;
  logic        cause_fault;
  // mirror registers
  logic        ov_en, ov_sdwn, fs_bypass;
  logic [1:0]  ov_dbnc;
  logic [3:0]  fs_limit, wd_limit;
  logic [2:0]  period_sel;
  logic [3:0]  fail_flags;
  logic [3:0]  failsafe_counter, wd_cnt;
  logic [39:0] minute_cnt;
  logic [5:0]  minutes;
  logic        period_hit;
  logic        apb_wr, apb_rd, mapped;
  logic        fs_clr_req;
  logic [3:0]  flag_clr;

  function automatic logic wr_hit(input logic [11:0] addr, input logic [11:0] ofs);
    wr_hit = (addr == ofs);
  endfunction

  // synchronisers, first stage read only by second
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      uv_s1  <= 1'b0;
      uv_s2  <= 1'b0;
      uv_q   <= 1'b0;
      ov_s1  <= 1'b0;
      ov_s2  <= 1'b0;
      wdi_s1 <= 1'b0;
      wdi_s2 <= 1'b0;
      wdi_q  <= 1'b0;
    end else if (I_CLK_EN) begin
      uv_s1  <= I_VIN_ABOVE_UV;
      uv_s2  <= uv_s1;
      uv_q   <= uv_s2;
      ov_s1  <= I_INPUT_OVERVOLTAGE_EVENT;
      ov_s2  <= ov_s1;
      wdi_s1 <= I_WATCHDOG_INPUT_PIN;
      wdi_s2 <= wdi_s1;
      wdi_q  <= wdi_s2;
    end
  end

  assign uv_rise = uv_s2 & ~uv_q;

  always_comb begin
    unique case (ov_dbnc)
      fsseq_pkg::DBNC_SEL_10US:  dbnc_target = fsseq_pkg::DBNC_10US_CYC;
      fsseq_pkg::DBNC_SEL_100US: dbnc_target = DBNC_100US_CYCLES;
      default:                   dbnc_target = DBNC_1MS_CYCLES;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      dbnc_cnt <= 17'h00000;
      ov_deb   <= 1'b0;
      ov_deb_q <= 1'b0;
    end else if (I_CLK_EN) begin
      ov_deb_q <= ov_deb;
      if (!ov_s2 || !ov_en || !uv_s2) begin
        dbnc_cnt <= 17'h00000;
        ov_deb   <= 1'b0;
      end else if (dbnc_cnt >= dbnc_target - 17'h00001) begin
        ov_deb <= 1'b1;
      end else begin
        dbnc_cnt <= dbnc_cnt + 17'h00001;
      end
    end
  end

  assign ov_evt = ov_deb & ~ov_deb_q;

  assign wd_evt = (state == ST_SYS_ON) & ((wdi_s2 ^ wdi_q) | I_WD_TIMER_EVENT);
  assign next_wd_cnt = (wd_cnt == fsseq_pkg::CNT_MAX) ? wd_cnt : wd_cnt + 4'h1;
  assign wd_max = wd_evt & (next_wd_cnt == wd_limit);

  assign fault_src = {I_THERMAL_FAIL, I_REG_FAIL, 1'b0,
                      I_POWERUP_FAIL & (state == ST_POWER_UP)};
  assign fault_evt = ((state == ST_POWER_UP) | (state == ST_SYS_ON))
                   & (|fault_src | wd_max);

  // main state machine
  always_comb begin
    next_state = state;
    unique case (state)
      ST_UNPOWERED: begin
        if (uv_rise) begin
          next_state = ST_LOW_POWER_OFF_STATE;
        end
      end
      ST_LOW_POWER_OFF_STATE: begin
        if (I_TURN_ON) begin
          next_state = ST_POWER_UP;
        end
      end
      ST_POWER_UP: begin
        if (fault_evt || (ov_evt && ov_sdwn)) begin
          next_state = ST_POWER_DOWN;
        end else if (I_POWERUP_DONE) begin
          next_state = ST_SYS_ON;
        end
      end
      ST_SYS_ON: begin
        if (fault_evt || I_TURN_OFF || (ov_evt && ov_sdwn)) begin
          next_state = ST_POWER_DOWN;
        end
      end
      ST_POWER_DOWN: begin
        if (I_POWERDOWN_DONE) begin
          next_state = cause_fault ? ST_FS_TRANS : ST_LOW_POWER_OFF_STATE;
        end
      end
      ST_FS_TRANS: begin
        if (failsafe_counter == fs_limit && !fs_bypass) begin
          next_state = ST_LOCKDOWN;
        end else begin
          next_state = ST_LOW_POWER_OFF_STATE;
        end
      end
      ST_LOCKDOWN: next_state = ST_LOCKDOWN;
      default:     next_state = ST_UNPOWERED;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state <= ST_UNPOWERED;
    end else if (I_CLK_EN) begin
      if (!uv_s2) begin
        state <= ST_UNPOWERED;
      end else begin
        state <= next_state;
      end
    end
  end

  // fault cause latched on entering power down
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      cause       <= 4'h0;
      cause_fault <= 1'b0;
    end else if (I_CLK_EN) begin
      if (state != ST_POWER_DOWN && next_state == ST_POWER_DOWN) begin
        cause_fault <= fault_evt;
        if (fault_src[fsseq_pkg::FAIL_PU]) begin
          cause <= 4'h1 << fsseq_pkg::FAIL_PU;
        end else if (wd_max) begin
          cause <= 4'h1 << fsseq_pkg::FAIL_WD;
        end else if (fault_src[fsseq_pkg::FAIL_REG]) begin
          cause <= 4'h1 << fsseq_pkg::FAIL_REG;
        end else if (fault_src[fsseq_pkg::FAIL_TSD]) begin
          cause <= 4'h1 << fsseq_pkg::FAIL_TSD;
        end else begin
          cause <= 4'h0;
        end
      end
    end
  end

  // apb decode
  assign apb_wr = I_PSEL & I_PENABLE & I_PWRITE;
  assign apb_rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign mapped = wr_hit(I_PADDR, fsseq_pkg::OFS_CTRL) | wr_hit(I_PADDR, fsseq_pkg::OFS_LIMITS)
                | wr_hit(I_PADDR, fsseq_pkg::OFS_FAIL) | wr_hit(I_PADDR, fsseq_pkg::OFS_COUNT);
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
  // clear by one, only when on
  assign flag_clr = (apb_wr && wr_hit(I_PADDR, fsseq_pkg::OFS_FAIL) && state == ST_SYS_ON)
                  ? I_PWDATA[3:0] : 4'h0;
  assign fs_clr_req = apb_wr & wr_hit(I_PADDR, fsseq_pkg::OFS_COUNT) & (state == ST_SYS_ON)
                    & I_PWDATA[fsseq_pkg::CNT_FS_CLR];

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_PRDATA <= 32'h00000000;
    end else if (I_CLK_EN) begin
      if (apb_rd) begin
        O_PRDATA <= 32'h00000000;
        if (wr_hit(I_PADDR, fsseq_pkg::OFS_CTRL)) begin
          O_PRDATA[fsseq_pkg::CTRL_OV_EN]     <= ov_en;
          O_PRDATA[fsseq_pkg::CTRL_OV_SDWN]   <= ov_sdwn;
          O_PRDATA[fsseq_pkg::CTRL_OV_DBNC+:2] <= ov_dbnc;
          O_PRDATA[fsseq_pkg::CTRL_FS_BYPASS] <= fs_bypass;
        end else if (wr_hit(I_PADDR, fsseq_pkg::OFS_LIMITS)) begin
          O_PRDATA[fsseq_pkg::LIM_FS+:4]     <= fs_limit;
          O_PRDATA[fsseq_pkg::LIM_WD+:4]     <= wd_limit;
          O_PRDATA[fsseq_pkg::LIM_PERIOD+:3] <= period_sel;
        end else if (wr_hit(I_PADDR, fsseq_pkg::OFS_FAIL)) begin
          O_PRDATA[3:0] <= fail_flags;
        end else if (wr_hit(I_PADDR, fsseq_pkg::OFS_COUNT)) begin
          O_PRDATA[fsseq_pkg::CNT_FS+:4]    <= failsafe_counter;
          O_PRDATA[fsseq_pkg::CNT_WD+:4]    <= wd_cnt;
          O_PRDATA[fsseq_pkg::CNT_STATE+:3] <= state;
        end
      end
    end
  end

  // mirror registers
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      ov_en      <= 1'b0;
      ov_sdwn    <= 1'b0;
      ov_dbnc    <= 2'h0;
      fs_bypass  <= 1'b0;
      fs_limit   <= 4'h0;
      wd_limit   <= 4'h0;
      period_sel <= 3'h0;
    end else if (I_CLK_EN) begin
      if (uv_rise) begin
        ov_en      <= I_OVERVOLTAGE_ENABLE_DEFAULT;
        ov_sdwn    <= I_OVERVOLTAGE_SHUTDOWN_DEFAULT;
        ov_dbnc    <= I_OVERVOLTAGE_DEBOUNCE_DEFAULT;
        fs_bypass  <= I_FAILSAFE_BYPASS_DEFAULT;
        fs_limit   <= I_FAILSAFE_LIMIT_DEFAULT;
        wd_limit   <= I_WATCHDOG_EVENT_LIMIT_DEFAULT;
        period_sel <= I_FAILSAFE_DECREMENT_PERIOD_SEL;
      end else if (apb_wr && wr_hit(I_PADDR, fsseq_pkg::OFS_CTRL)) begin
        ov_en     <= I_PWDATA[fsseq_pkg::CTRL_OV_EN];
        ov_sdwn   <= I_PWDATA[fsseq_pkg::CTRL_OV_SDWN];
        ov_dbnc   <= I_PWDATA[fsseq_pkg::CTRL_OV_DBNC+:2];
        fs_bypass <= I_PWDATA[fsseq_pkg::CTRL_FS_BYPASS];
      end else if (apb_wr && wr_hit(I_PADDR, fsseq_pkg::OFS_LIMITS)) begin
        fs_limit   <= I_PWDATA[fsseq_pkg::LIM_FS+:4];
        wd_limit   <= I_PWDATA[fsseq_pkg::LIM_WD+:4];
        period_sel <= I_PWDATA[fsseq_pkg::LIM_PERIOD+:3];
      end
    end
  end

  // failure flags, set wins over clear
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      fail_flags <= 4'h0;
    end else if (I_CLK_EN) begin
      if (!uv_s2) begin
        fail_flags <= 4'h0;
      end else if (state == ST_FS_TRANS) begin
        fail_flags <= (fail_flags & ~flag_clr) | cause;
      end else begin
        fail_flags <= fail_flags & ~flag_clr;
      end
    end
  end

  // watchdog event counter
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      wd_cnt          <= fsseq_pkg::CNT_RESET;
      O_WD_HARD_RESET <= 1'b0;
    end else if (I_CLK_EN) begin
      O_WD_HARD_RESET <= 1'b0;
      if (uv_rise) begin
        wd_cnt <= fsseq_pkg::CNT_RESET;
      end else if (wd_evt) begin
        wd_cnt <= next_wd_cnt;
        O_WD_HARD_RESET <= ~wd_max & ~(|fault_src);
      end
    end
  end

  assign period_hit = (minutes == fsseq_pkg::FS_PERIOD_MIN[period_sel]);

  // decrement timer runs only while on and counter nonzero
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      minute_cnt <= 40'h0000000000;
      minutes    <= 6'h00;
    end else if (I_CLK_EN) begin
      if (state != ST_SYS_ON || failsafe_counter == fsseq_pkg::CNT_RESET || period_hit) begin
        minute_cnt <= 40'h0000000000;
        minutes    <= 6'h00;
      end else if (minute_cnt >= MINUTE_CYCLES - 40'h0000000001) begin
        minute_cnt <= 40'h0000000000;
        minutes    <= minutes + 6'h01;
      end else begin
        minute_cnt <= minute_cnt + 40'h0000000001;
      end
    end
  end

  // fail-safe counter
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      failsafe_counter <= fsseq_pkg::CNT_RESET;
    end else if (I_CLK_EN) begin
      if (uv_rise) begin
        failsafe_counter <= fsseq_pkg::CNT_RESET;
      end else if (state == ST_FS_TRANS) begin
        if (failsafe_counter != fsseq_pkg::CNT_MAX) begin
          failsafe_counter <= failsafe_counter + 4'h1;
        end
      end else if (fs_clr_req) begin
        failsafe_counter <= fsseq_pkg::CNT_RESET;
      end else if (state == ST_SYS_ON && period_hit && failsafe_counter != fsseq_pkg::CNT_RESET) begin
        failsafe_counter <= failsafe_counter - 4'h1;
      end
    end
  end

  // event pulses
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_FUSE_LOAD <= 1'b0;
      O_OV_IRQ    <= 1'b0;
    end else if (I_CLK_EN) begin
      O_FUSE_LOAD <= uv_rise;
      O_OV_IRQ <= ov_evt & ~ov_sdwn & uv_s2;
    end
  end

  // level outputs straight from the state register
  assign O_POWERUP_REQ   = (state == ST_POWER_UP);
  assign O_POWERDOWN_REQ = (state == ST_POWER_DOWN);
  assign O_REGULATORS_ON = (state == ST_POWER_UP) | (state == ST_SYS_ON);
  assign O_LOCKDOWN      = (state == ST_LOCKDOWN);
  assign O_STATE         = state;

endmodule // fault_failsafe_sequencer

// ==== test/fsseq_properties.sv ====
`timescale 1ns/10ps
module fsseq_properties (
  // clock and reset
  input wire logic       I_MCLK,
  input wire logic       I_RST,
  // watched inputs
  input wire logic       I_VIN_ABOVE_UV,
  input wire logic       I_INPUT_OVERVOLTAGE_EVENT,
  input wire logic       I_REG_FAIL,
  input wire logic       I_THERMAL_FAIL,
  input wire logic       I_POWERDOWN_DONE,
  // watched outputs
  input wire logic       O_FUSE_LOAD,
  input wire logic       O_WD_HARD_RESET,
  input wire logic       O_OV_IRQ,
  input wire logic       O_LOCKDOWN,
  input wire logic [2:0] O_STATE
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  chk_fuse_load: assert property (O_STATE == 3'h1 && $past(O_STATE) == 3'h0 |-> O_FUSE_LOAD)
    else $error("fuse load pulse missing");
  chk_uv_low: assert property (!I_VIN_ABOVE_UV [*4] |-> O_STATE == 3'h0)
    else $error("not unpowered with supply low");
  chk_pd_end: assert property (O_STATE == 3'h4 && I_POWERDOWN_DONE |=> O_STATE inside {3'h1, 3'h5})
    else $error("bad exit from power down");
  chk_fs_exit: assert property (O_STATE == 3'h5 |=> O_STATE inside {3'h1, 3'h6})
    else $error("bad exit from fail-safe transition");
  chk_lock_hold: assert property (I_VIN_ABOVE_UV [*3] ##0 O_STATE == 3'h6 |=> O_STATE == 3'h6 && O_LOCKDOWN)
    else $error("lock-down left with supply up");
  chk_fault_pd: assert property (O_STATE == 3'h3 && (I_REG_FAIL || I_THERMAL_FAIL) |=> O_STATE == 3'h4)
    else $error("fault did not start power down");
  chk_wd_reset: assert property (O_WD_HARD_RESET |-> $past(O_STATE) == 3'h3 && O_STATE == 3'h3)
    else $error("hard reset outside on state");
  chk_ov_irq: assert property (O_OV_IRQ |-> $past(I_INPUT_OVERVOLTAGE_EVENT, 8))
    else $error("irq without held overvoltage");
  cover property (O_STATE == 3'h6);
  cover property (O_WD_HARD_RESET);
  cover property (O_OV_IRQ);
endmodule // fsseq_properties

bind fault_failsafe_sequencer fsseq_properties i_fsseq_properties (
  .I_MCLK, .I_RST, .I_VIN_ABOVE_UV, .I_INPUT_OVERVOLTAGE_EVENT, .I_REG_FAIL,
  .I_THERMAL_FAIL, .I_POWERDOWN_DONE, .O_FUSE_LOAD, .O_WD_HARD_RESET, .O_OV_IRQ,
  .O_LOCKDOWN, .O_STATE
);

// ==== test/fsseq_partner.sv ====
`timescale 1ns/10ps
module fsseq_partner (
  // clock
  input wire logic       i_mclk,
  // sequencer requests and pacing
  input wire logic       i_powerup_req,
  input wire logic       i_powerdown_req,
  input wire logic [7:0] i_delay,
  input wire logic       i_powerup_bad,
  input wire logic       i_wd_kick,
  // answers
  output logic           o_powerup_done,
  output logic           o_powerup_fail,
  output logic           o_powerdown_done,
  output logic           o_watchdog_input_pin
);
  logic [1:0] req_seen = 2'h0;
  logic [7:0] elapsed  = 8'h00;
  logic       steady;
  // a fresh request must not meet a stale count left from the idle time
  assign steady = ({i_powerup_req, i_powerdown_req} == req_seen);
  initial begin
    o_powerup_done = 1'b0;
    o_powerup_fail = 1'b0;
    o_powerdown_done = 1'b0;
    o_watchdog_input_pin = 1'b0;
  end
  // pacing restarts whenever the request changes, so slow answers stay exact
  always @(posedge i_mclk) begin
    req_seen <= {i_powerup_req, i_powerdown_req};
    elapsed <= steady ? elapsed + 8'h01 : 8'h00;
    o_powerdown_done <= i_powerdown_req && steady && elapsed == i_delay;
    o_powerup_done <= i_powerup_req && steady && elapsed == i_delay && !i_powerup_bad;
    o_powerup_fail <= i_powerup_req && steady && elapsed == i_delay && i_powerup_bad;
    if (i_wd_kick) begin
      o_watchdog_input_pin <= !o_watchdog_input_pin;
    end
  end
endmodule // fsseq_partner

// ==== test/tb_fault_failsafe_sequencer.sv ====
`timescale 1ns/10ps
module tb_fault_failsafe_sequencer;
  localparam logic [11:0] RC = fsseq_pkg::OFS_CTRL;
  localparam logic [11:0] RL = fsseq_pkg::OFS_LIMITS;
  localparam logic [11:0] RF = fsseq_pkg::OFS_FAIL;
  localparam logic [11:0] RN = fsseq_pkg::OFS_COUNT;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        uv = 1'b1;
  logic        ovp = 1'b0;
  logic [5:0]  evt = 6'h00;
  logic        pu_bad = 1'b0;
  logic [7:0]  delay = 8'h03;
  logic        fs_byp = 1'b0;
  logic [2:0]  fs_sel = 3'h0;
  logic        ov_sd = 1'b0;
  logic [31:0] prdata, r;
  logic [2:0]  state;
  logic        pready, pslverr, se, pu_req, pd_req, pu_done, powerup_failure_flag, pd_done, wd_pin;
  logic        wd_rst, ov_irq, lock;
  logic        ce = 1'b1;
  logic        fuse_ld, reg_on;
  int          err_total = 0;
  int          compares = 0;
  int          wd_hits = 0;
  int          ov_hits = 0;
  int          fl_hits = 0;

  fault_failsafe_sequencer #(.MINUTE_CYCLES(40'd100), .DBNC_100US_CYCLES(17'd20),
    .DBNC_1MS_CYCLES(17'd40)) i_fault_failsafe_sequencer (
    .I_MCLK(mclk), .I_RST(rst), .I_CLK_EN(ce), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_VIN_ABOVE_UV(uv),
    .I_INPUT_OVERVOLTAGE_EVENT(ovp), .I_WATCHDOG_INPUT_PIN(wd_pin), .I_WD_TIMER_EVENT(evt[2]),
    .I_TURN_ON(evt[0]), .I_TURN_OFF(evt[1]), .I_POWERUP_DONE(pu_done),
    .I_POWERUP_FAIL(powerup_failure_flag), .I_POWERDOWN_DONE(pd_done), .I_REG_FAIL(evt[3]),
    .I_THERMAL_FAIL(evt[4]), .I_FAILSAFE_LIMIT_DEFAULT(4'h2),
    .I_FAILSAFE_BYPASS_DEFAULT(fs_byp), .I_FAILSAFE_DECREMENT_PERIOD_SEL(fs_sel),
    .I_WATCHDOG_EVENT_LIMIT_DEFAULT(4'h2), .I_OVERVOLTAGE_ENABLE_DEFAULT(1'b1),
    .I_OVERVOLTAGE_SHUTDOWN_DEFAULT(ov_sd), .I_OVERVOLTAGE_DEBOUNCE_DEFAULT(2'h1),
    .O_FUSE_LOAD(fuse_ld), .O_POWERUP_REQ(pu_req), .O_POWERDOWN_REQ(pd_req),
    .O_REGULATORS_ON(reg_on),
    .O_WD_HARD_RESET(wd_rst), .O_OV_IRQ(ov_irq), .O_LOCKDOWN(lock), .O_STATE(state));

  fsseq_partner i_fsseq_partner (.i_mclk(mclk), .i_powerup_req(pu_req),
    .i_powerdown_req(pd_req), .i_delay(delay), .i_powerup_bad(pu_bad), .i_wd_kick(evt[5]),
    .o_powerup_done(pu_done), .o_powerup_fail(powerup_failure_flag), .o_powerdown_done(pd_done),
    .o_watchdog_input_pin(wd_pin));

  initial begin
    forever #4 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    if (wd_rst === 1'b1) wd_hits++;
    if (ov_irq === 1'b1) ov_hits++;
    if (fuse_ld === 1'b1) fl_hits++;
  end

  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // the wait on pready is left open; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask
  task automatic pulse(input int k);
    @(posedge mclk);
    evt[k] <= 1'b1;
    @(posedge mclk);
    evt[k] <= 1'b0;
  endtask
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (state !== s && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    chk({29'h0, state}, {29'h0, s});
  endtask
  task automatic power_on();
    pulse(0);
    wait_st(3'h3);
  endtask
  task automatic ov_burst();
    @(posedge mclk);
    ovp <= 1'b1;
    repeat (40) @(posedge mclk);
    ovp <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask

  initial begin
    #200000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    wait_st(3'h1);
    rd(RL, ALL, 32'h022);
    rd(RC, ALL, 32'h05);
    chk(fl_hits, 1);
    @(posedge mclk);
    ce <= 1'b0;
    pulse(0);
    chk({29'h0, state}, 32'h1);
    @(posedge mclk);
    ce <= 1'b1;
    rd(12'h010, ALL, 32'h0);
    chk(se, 1'b1);
    power_on();
    pulse(5);
    repeat (8) @(posedge mclk);
    chk(wd_hits, 1);
    rd(RN, 32'h7FF, 32'h310);
    pulse(2);
    wait_st(3'h1);
    chk(wd_hits, 1);
    rd(RF, ALL, 32'h2);
    rd(RN, 32'h70F, 32'h101);
    power_on();
    rd(RF, ALL, 32'h2);
    apb(1'b1, RF, 32'h2);
    rd(RF, ALL, 32'h0);
    repeat (110) @(posedge mclk);
    rd(RN, 32'hF, 32'h0);
    pulse(1);
    wait_st(3'h4);
    wait_st(3'h1);
    rd(RF, ALL, 32'h0);
    chk(reg_on, 1'b0);
    apb(1'b1, RC, 32'h15);
    apb(1'b1, RL, 32'h020);
    power_on();
    pulse(4);
    wait_st(3'h4);
    wait_st(3'h1);
    chk(lock, 1'b0);
    rd(RF, ALL, 32'h8);
    power_on();
    rd(RN, 32'hF, 32'h1);
    apb(1'b1, RN, 32'h10000);
    rd(RN, 32'hF, 32'h0);
    apb(1'b1, RC, 32'h05);
    pulse(3);
    wait_st(3'h6);
    chk(lock, 1'b1);
    rd(RF, ALL, 32'hC);
    pulse(0);
    repeat (5) @(negedge mclk);
    wait_st(3'h6);
    @(posedge mclk);
    fs_sel <= 3'h1;
    ov_sd <= 1'b1;
    fs_byp <= 1'b1;
    uv <= 1'b0;
    repeat (10) @(negedge mclk);
    wait_st(3'h0);
    @(posedge mclk);
    uv <= 1'b1;
    wait_st(3'h1);
    rd(RL, ALL, 32'h122);
    rd(RC, ALL, 32'h17);
    chk(fl_hits, 2);
    rd(RN, 32'hFF, 32'h0);
    @(posedge mclk);
    delay <= 8'd80;
    pulse(0);
    ov_burst();
    wait_st(3'h4);
    wait_st(3'h1);
    chk(ov_hits, 0);
    @(posedge mclk);
    delay <= 8'h03;
    power_on();
    ov_burst();
    wait_st(3'h1);
    apb(1'b1, RC, 32'h05);
    @(posedge mclk);
    delay <= 8'd80;
    pulse(0);
    ov_burst();
    chk({29'h0, state}, 32'h2);
    chk(reg_on, 1'b1);
    wait_st(3'h3);
    chk(ov_hits, 1);
    @(posedge mclk);
    delay <= 8'h03;
    apb(1'b1, RC, 32'h04);
    ov_burst();
    chk(ov_hits, 1);
    pulse(1);
    wait_st(3'h1);
    @(posedge mclk);
    pu_bad <= 1'b1;
    pulse(0);
    wait_st(3'h4);
    wait_st(3'h1);
    rd(RF, ALL, 32'h1);
    final_report();
  end
endmodule // tb_fault_failsafe_sequencer
